// ---- card_host_signal_interface.sv ----
`timescale 1ns/1ps
// Host signal handling of a removable flash card: decode, lanes, fixed outputs, alert, master/slave
module card_host_signal_interface (
  input  wire logic        clk_sys,            // System clock, 40 MHz
  input  wire logic        srst,               // Synchronous reset, active high
  input  wire logic        powerUpOe_n,        // Output enable pin level at power up
  input  wire logic [10:0] hostAddr,           // Host address lines
  input  wire logic        attrSelect_n,       // Attribute space select, active low
  input  wire logic        card_enable_low_n,  // First card enable / task file select
  input  wire logic        card_enable_high_n, // Second card enable / control block select
  input  wire logic        cable_select_n,     // Cable select pin (pulled up outside)
  input  wire logic        dataXfer,           // Core: current access is a 16-bit data transfer
  input  wire logic        readCycle,          // Core: current access is a read
  input  wire logic [15:0] coreRdData,         // Core: read word, even byte in low bits
  input  wire logic [15:0] hostDataIn,         // Data lines as seen from the pins
  input  wire logic        ready_busy_state,   // Core: ready (1) or busy (0)
  input  wire logic        writeProtect,       // Core: write protect state
  input  wire logic        alertEnable,        // Core: alert enable from config and status register
  input  wire logic        ioModeSel,          // Core: I/O interface configured by the config register
  input  wire logic        pass_diag_n_in,     // Pass diagnostic pin level
  input  wire logic        passDiagAssert,     // Core: assert pass diagnostic
  input  wire logic        drive_active_slave_present_n_in, // Drive active/slave present pin level
  input  wire logic        driveActiveAssert,  // Core: assert drive active/slave present
  output card_if_pkg::mode_type   mode,        // Interface personality
  output card_if_pkg::access_type access,      // Decoded access toward the core
  output logic [15:0]      hostDataOut,        // Data lines driven to host
  output logic [15:0]      hostDataOe,         // Output enable per data line
  output logic [15:0]      coreWrData,         // Write data steered into byte order
  output logic             isMaster,           // IDE: configured as master
  output logic             batt_detect_one,    // First battery detect / alert pin value
  output logic             batt_detect_one_oe, // Enable for that pin
  output logic             batt_detect_two,    // Second battery detect / audio pin value
  output logic             batt_detect_two_oe, // Enable for that pin
  output logic             pass_diag_n_out,    // Pass diagnostic pin value
  output logic             pass_diag_n_oe,     // Pass diagnostic drive enable
  output logic             drive_active_slave_present_n_out, // Drive active pin value
  output logic             drive_active_slave_present_n_oe,  // Drive active drive enable
  output logic             insert_detect_a_n,  // First insert detect, tied low
  output logic             insert_detect_b_n   // Second insert detect, tied low
);

  // Synchronised pin inputs
  logic [10:0] addrSync;      // Address lines
  logic [3:0]  ctlSync;       // Attribute select, two enables, cable select (active low)
  logic [2:0]  miscSync;      // Output enable, diag pin, active pin
  logic [15:0] dataSync;      // Data lines

  pin_sync #(.WIDTH(11)) uAddrSync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .rstVal  (11'h000),
    .din     (hostAddr),
    .dout    (addrSync)
  );

  pin_sync #(.WIDTH(4)) uCtlSync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .rstVal  (4'hF),
    .din     ({attrSelect_n, card_enable_low_n, card_enable_high_n, cable_select_n}),
    .dout    (ctlSync)
  );

  pin_sync #(.WIDTH(3)) uMiscSync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .rstVal  (3'h7),
    .din     ({powerUpOe_n, pass_diag_n_in, drive_active_slave_present_n_in}),
    .dout    (miscSync)
  );

  pin_sync #(.WIDTH(16)) uDataSync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .rstVal  (16'h0000),
    .din     (hostDataIn),
    .dout    (dataSync)
  );

  card_if_pkg::host_req_type req;  // Request in active-high form
  assign req = '{addr: addrSync, attrSel: ~ctlSync[3], enLow: ~ctlSync[2], enHigh: ~ctlSync[1]};

  // Mode strap state
  card_if_pkg::mode_type modeR_r;     // Current mode
  card_if_pkg::mode_type modeR_nxt;   // Next mode
  logic [1:0]            strapCnt_r;    // Edges since reset release, stops at 3
  logic [1:0]            strapCnt_nxt;  // Next edge count
  logic                  master_r;      // Master/slave setting
  logic                  master_nxt;    // Next master/slave

  // Strap capture: the synchroniser holds reset values, so wait until the pin level reaches its output
  always_comb begin
    modeR_nxt    = modeR_r;
    strapCnt_nxt = strapCnt_r;
    master_nxt   = master_r;
    if (strapCnt_r != 2'h3) begin
      strapCnt_nxt = strapCnt_r + 2'h1;
    end
    if (strapCnt_r == 2'h2) begin
      modeR_nxt = miscSync[2] ? card_if_pkg::MODE_MEMORY : card_if_pkg::MODE_IDE;
    end else if (strapCnt_r == 2'h3 && modeR_r != card_if_pkg::MODE_IDE) begin
      modeR_nxt = ioModeSel ? card_if_pkg::MODE_IO : card_if_pkg::MODE_MEMORY;   // Configured personality
    end
    if (modeR_r == card_if_pkg::MODE_IDE) begin
      master_nxt = ~ctlSync[0];   // Grounded pin means master
    end else begin
      master_nxt = 1'b0;          // Pin ignored outside IDE mode
    end
  end

  // Strap registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      modeR_r     <= card_if_pkg::MODE_MEMORY;
      strapCnt_r  <= 2'h0;
      master_r    <= 1'b0;
    end else begin
      modeR_r     <= modeR_nxt;
      strapCnt_r  <= strapCnt_nxt;
      master_r    <= master_nxt;
    end
  end

  assign mode     = modeR_r;
  assign isMaster = master_r;

  // Decode of space and byte lanes
  card_if_pkg::access_type acc;   // Combinational decode
  always_comb begin
    acc = '{space: card_if_pkg::SEL_NONE, offset: 11'h000, evenByte: 1'b0, oddByte: 1'b0, oddOnLow: 1'b0};
    unique case (modeR_r)
      card_if_pkg::MODE_IDE: begin
        if (req.enLow || req.enHigh) begin
          // Only the low three address bits matter; upper bits grounded by host
          acc.offset   = {8'h00, req.addr[card_if_pkg::TF_ADDR_W-1:0]};
          acc.space    = req.enLow ? card_if_pkg::SEL_TASKFILE : card_if_pkg::SEL_CTRL_BLOCK;
          acc.evenByte = 1'b1;
          acc.oddByte  = req.enLow && dataXfer && req.addr[2:0] == 3'h0; // Word only for data
        end
      end
      default: begin
        if (req.enLow || req.enHigh) begin
          acc.offset = req.addr;
          if (!req.attrSel) begin
            acc.space = (modeR_r == card_if_pkg::MODE_IO) ? card_if_pkg::SEL_IO_PORT : card_if_pkg::SEL_COMMON;
          end else if (req.addr >= card_if_pkg::CONFIG_BASE) begin
            acc.space = card_if_pkg::SEL_CONFIG;
          end else begin
            acc.space = card_if_pkg::SEL_CIS;
          end
          if (req.enHigh) begin
            acc.oddByte = 1'b1;
          end
          if (req.enLow && req.enHigh) begin
            acc.evenByte = 1'b1;                                     // Word access
          end else if (req.enLow) begin
            acc.evenByte = ~req.addr[card_if_pkg::ADDR_LSB];
            acc.oddByte  = req.addr[card_if_pkg::ADDR_LSB];
            acc.oddOnLow = req.addr[card_if_pkg::ADDR_LSB];          // Odd byte on low lane
          end
        end
      end                                                            // Neither enable: nothing
    endcase
  end

  // Registered data path state
  card_if_pkg::access_type accR_r;   // Registered decode
  logic [15:0] dOut_r, dOut_nxt;     // Data out
  logic [15:0] dOe_r, dOe_nxt;       // Data enables
  logic [15:0] wr_r, wr_nxt;         // Write data

  // Lane steering of read and write data
  always_comb begin
    dOut_nxt = 16'h0000;
    dOe_nxt  = 16'h0000;                                             // Undriven unless selected
    wr_nxt   = wr_r;
    if (acc.oddOnLow) begin
      dOut_nxt[7:0] = coreRdData[15:8];
      wr_nxt[15:8]  = dataSync[7:0];
      dOe_nxt[7:0]  = {8{readCycle}};
    end else begin
      if (acc.evenByte) begin
        dOut_nxt[7:0] = coreRdData[7:0];                             // Even byte low lane
        wr_nxt[7:0]   = dataSync[7:0];
        dOe_nxt[7:0]  = {8{readCycle}};
      end
      if (acc.oddByte) begin
        dOut_nxt[15:8] = coreRdData[15:8];                           // Odd byte high lane
        wr_nxt[15:8]   = dataSync[15:8];
        dOe_nxt[15:8]  = {8{readCycle}};
      end
    end
  end

  // Data path registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      accR_r <= '{space: card_if_pkg::SEL_NONE, offset: 11'h000, evenByte: 1'b0, oddByte: 1'b0, oddOnLow: 1'b0};
      dOut_r <= 16'h0000;
      dOe_r  <= 16'h0000;
      wr_r   <= 16'h0000;
    end else begin
      accR_r <= acc;
      dOut_r <= dOut_nxt;
      dOe_r  <= dOe_nxt;
      wr_r   <= wr_nxt;
    end
  end

  assign access      = accR_r;
  assign hostDataOut = dOut_r;
  assign hostDataOe  = dOe_r;
  assign coreWrData  = wr_r;

  // Status change alert state
  logic [1:0] prevState_r, prevState_nxt; // Last ready/protect values
  logic       alert_r, alert_nxt;         // Alert latched, pin low while set

  // Alert on change of ready or protect; clear wins over a new change
  always_comb begin
    prevState_nxt = {ready_busy_state, writeProtect};
    alert_nxt     = alert_r;
    if (modeR_r != card_if_pkg::MODE_IO || !alertEnable) begin
      alert_nxt = 1'b0;
    end
    if (modeR_r == card_if_pkg::MODE_IO && alertEnable &&
        prevState_r != {ready_busy_state, writeProtect}) begin
      alert_nxt = 1'b1;
    end
  end

  // Alert registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prevState_r <= 2'h0;
      alert_r     <= 1'b0;
    end else begin
      prevState_r <= prevState_nxt;
      alert_r     <= alert_nxt;
    end
  end

  // Dual-use pins per mode
  always_comb begin
    batt_detect_one    = 1'b1;
    batt_detect_one_oe = 1'b0;
    batt_detect_two    = 1'b1;
    batt_detect_two_oe = 1'b0;
    pass_diag_n_out    = 1'b1;
    pass_diag_n_oe     = 1'b0;
    drive_active_slave_present_n_out = 1'b1;
    drive_active_slave_present_n_oe  = 1'b0;
    unique case (modeR_r)
      card_if_pkg::MODE_MEMORY: begin
        batt_detect_one_oe = 1'b1;
        batt_detect_two_oe = 1'b1;
      end
      card_if_pkg::MODE_IO: begin
        batt_detect_one    = ~alert_r;                               // Alert pulls low
        batt_detect_one_oe = 1'b1;
        batt_detect_two_oe = 1'b1;                                   // Audio held high
      end
      card_if_pkg::MODE_IDE: begin
        pass_diag_n_out = 1'b0;                                      // Open drain style
        pass_diag_n_oe  = passDiagAssert;
        drive_active_slave_present_n_out = 1'b0;
        drive_active_slave_present_n_oe  = driveActiveAssert;
      end
      default: begin
      end
    endcase
  end

  assign insert_detect_a_n = 1'b0;
  assign insert_detect_b_n = 1'b0;

endmodule : card_host_signal_interface

// ---- card_if_pkg.sv ----
// Package with modes, decode classes, carried structs and constants of the card host interface
package card_if_pkg;

  // Interface personality: strap at power-up picks ATA or not, config register picks memory or I/O
  typedef enum logic [1:0] {
    MODE_MEMORY,
    MODE_IO,
    MODE_IDE
  } mode_type;

  // Register space chosen by one access
  typedef enum logic [2:0] {
    SEL_NONE,                      // No access decoded
    SEL_COMMON,                    // Common memory (memory mapped registers)
    SEL_IO_PORT,                   // I/O port registers
    SEL_CIS,                       // Attribute memory, card information bytes
    SEL_CONFIG,                    // Attribute memory, configuration registers
    SEL_TASKFILE,                  // ATA task file
    SEL_CTRL_BLOCK                 // Alternate status / device control
  } space_type;

  // Byte lane steering of one access
  typedef enum logic [2:0] {
    LANE_NONE,                     // Data bus not driven
    LANE_EVEN_LOW,                 // Even byte on low lane
    LANE_ODD_LOW,                  // Odd byte on low lane (8-bit host)
    LANE_ODD_HIGH,                 // Odd byte on high lane
    LANE_WORD                      // Both bytes
  } lane_dummy_type;

  localparam int ADDR_W        = 11;               // Host address lines
  localparam int DATA_W        = 16;               // Host data lines
  localparam int BYTE_W        = 8;                // One byte lane
  localparam int TF_ADDR_W     = 3;                // Task file index width
  localparam logic [10:0] CONFIG_BASE = 11'h200;   // Configuration registers in attribute space
  localparam int ADDR_LSB      = 0;                // Byte select bit position

  // Access request from the host pins, already synchronised
  typedef struct packed {
    logic [10:0] addr;             // Address lines
    logic        attrSel;          // Attribute space select, active high
    logic        enLow;            // First card enable / task file select, active high
    logic        enHigh;           // Second card enable / control block select, active high
  } host_req_type;

  // Decoded access toward the card core
  typedef struct packed {
    space_type   space;            // Selected register space
    logic [10:0] offset;           // Byte address within the space
    logic        evenByte;         // Even byte accessed
    logic        oddByte;          // Odd byte accessed
    logic        oddOnLow;         // Odd byte steered to the low lane
  } access_type;

endpackage : card_if_pkg

// ---- pin_sync.sv ----
`timescale 1ns/1ps
// Two flip-flop synchroniser for a group of pin inputs
module pin_sync #(
  parameter int WIDTH = 1          // Number of bits synchronised
) (
  input  wire logic             clk_sys,  // System clock
  input  wire logic             srst,     // Synchronous reset, active high
  input  wire logic [WIDTH-1:0] rstVal,   // Level taken during reset (constant at use)
  input  wire logic [WIDTH-1:0] din,      // Asynchronous input
  output logic      [WIDTH-1:0] dout      // Synchronised output
);

  logic [WIDTH-1:0] stage1_r;  // First stage, read only by the second
  logic [WIDTH-1:0] stage2_r;  // Second stage

  // Two registers in series
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stage1_r <= rstVal;
      stage2_r <= rstVal;
    end else begin
      stage1_r <= din;
      stage2_r <= stage1_r;
    end
  end

  assign dout = stage2_r;

endmodule : pin_sync

// ---- host_bus_model.sv ----
// Host bus controller model driving address, space select and card enables
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic                      clk_sys,            // Clock
  input  wire logic                      go,                 // Hold the requested access
  input  wire logic                      ideHost,            // Host runs the ATA personality
  input  wire card_if_pkg::host_req_type req,                // Requested pin state
  output logic [10:0]                    hostAddr,           // Address pins
  output logic                           attrSelect_n,       // Space select pin
  output logic                           card_enable_low_n,  // First enable pin
  output logic                           card_enable_high_n  // Second enable pin
);
  logic [10:0] idlePat = 11'h555;  // Changing address between accesses

  // Pins change just after a rising edge and hold until the next request
  always @(posedge clk_sys) begin
    idlePat <= ~idlePat;
    if (go) begin
      hostAddr <= ideHost ? {8'h00, req.addr[2:0]} : req.addr;
      attrSelect_n <= ~req.attrSel;
      card_enable_low_n <= ~req.enLow;
      card_enable_high_n <= ~req.enHigh;
    end else begin
      hostAddr <= ideHost ? {8'h00, idlePat[2:0]} : idlePat;
      attrSelect_n <= idlePat[0];
      card_enable_low_n <= 1'b1;
      card_enable_high_n <= 1'b1;
    end
  end

endmodule : host_bus_model

// ---- card_host_signal_interface_assertions.sv ----
// Checker of the card host interface pin behaviour
`timescale 1ns/1ps
module card_host_signal_interface_assertions (
  input wire logic                    clk_sys,            // Clock
  input wire logic                    srst,               // Reset
  input wire logic [10:0]             hostAddr,           // Address
  input wire logic                    card_enable_low_n,  // First enable
  input wire logic                    card_enable_high_n, // Second enable
  input wire logic                    cable_select_n,     // Cable select
  input wire logic                    readCycle,          // Read access
  input wire logic                    ready_busy_state,   // Ready state
  input wire logic                    alertEnable,        // Alert enable
  input wire card_if_pkg::mode_type   mode,               // Personality
  input wire card_if_pkg::access_type access,             // Decode
  input wire logic [15:0]             hostDataOe,         // Lane enables
  input wire logic                    isMaster,           // Master flag
  input wire logic                    batt_detect_one,    // Pin value
  input wire logic                    batt_detect_one_oe, // Pin enable
  input wire logic                    batt_detect_two,    // Pin value
  input wire logic                    batt_detect_two_oe, // Pin enable
  input wire logic                    insert_detect_a_n,  // Detect a
  input wire logic                    insert_detect_b_n   // Detect b
);
  wire logic ide = (mode == card_if_pkg::MODE_IDE);     // ATA personality
  wire logic ioM = (mode == card_if_pkg::MODE_IO);      // I/O personality
  wire logic memM = (mode == card_if_pkg::MODE_MEMORY); // Memory personality

  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);

  detect_tied_a: assert property (!insert_detect_a_n && !insert_detect_b_n)
    else $error("insert detect not low");
  batt_high_a: assert property (memM |-> batt_detect_one && batt_detect_one_oe && batt_detect_two)
    else $error("battery detect not high");
  audio_high_a: assert property (ioM |-> batt_detect_two && batt_detect_two_oe)
    else $error("audio output not high");
  alert_low_a: assert property (ioM && alertEnable && $changed(ready_busy_state) |=> !batt_detect_one)
    else $error("status alert missing");
  idle_bus_a: assert property ($past(card_enable_low_n, 3) && $past(card_enable_high_n, 3) && !ide
    |-> hostDataOe == 16'h0000 && access.space == card_if_pkg::SEL_NONE) else $error("idle bus driven");
  taskfile_a: assert property (ide && !$past(card_enable_low_n, 3) && $past(card_enable_high_n, 3)
    |-> access.space == card_if_pkg::SEL_TASKFILE && access.offset[2:0] == $past(hostAddr[2:0], 3))
    else $error("task file decode wrong");
  ctrl_block_a: assert property (ide && $past(card_enable_low_n, 3) && !$past(card_enable_high_n, 3)
    |-> access.space == card_if_pkg::SEL_CTRL_BLOCK) else $error("control block decode wrong");
  lane_word_a: assert property (!ide && readCycle && $past(readCycle, 3) && !$past(card_enable_low_n, 3)
    && !$past(card_enable_high_n, 3) |-> hostDataOe == 16'hFFFF) else $error("word lanes wrong");
  lane_low_a: assert property (!ide && readCycle && $past(readCycle, 3) && !$past(card_enable_low_n, 3)
    && $past(card_enable_high_n, 3) |-> hostDataOe == 16'h00FF && access.oddOnLow == $past(hostAddr[0], 3))
    else $error("low lane steering wrong");
  master_sel_a: assert property (ide && !$past(srst, 3) && $stable(cable_select_n) [*4]
    |-> isMaster == !cable_select_n) else $error("master select wrong");
  cable_select_n_ignored_a: assert property (!ide |-> !isMaster)
    else $error("master outside ATA mode");
endmodule : card_host_signal_interface_assertions

bind card_host_signal_interface card_host_signal_interface_assertions i_chk (
  .clk_sys, .srst, .hostAddr, .card_enable_low_n, .card_enable_high_n, .cable_select_n, .readCycle,
  .ready_busy_state, .alertEnable, .mode, .access, .hostDataOe, .isMaster, .batt_detect_one,
  .batt_detect_one_oe, .batt_detect_two, .batt_detect_two_oe, .insert_detect_a_n, .insert_detect_b_n
);

// ---- testbench.sv ----
// Self-checking bench of the card host signal interface
`timescale 1ns/1ps
module testbench;
  logic                      clk_sys = 1'b0, srst = 1'b1;        // Clock and reset
  logic                      powerUpOe_n = 1'b1, go = 1'b0;      // Strap level, hold access
  logic                      ideHost = 1'b0, cable_select_n = 1'b0; // Host personality, cable select
  card_if_pkg::host_req_type req = '0;                           // Requested pin state
  logic                      dataXfer = 1'b0, readCycle = 1'b1;  // Core access kind
  logic [15:0]               coreRdData = 16'h0000, hostDataIn = 16'h0000; // Data words
  logic                      ready_busy_state = 1'b1, writeProtect = 1'b0, alertEnable = 1'b1; // Status
  logic                      passDiagAssert = 1'b0, driveActiveAssert = 1'b0, ioModeSel = 1'b0; // Core levels
  logic [10:0]               hostAddr;                           // Address pins
  logic                      attrSelect_n, card_enable_low_n, card_enable_high_n; // Select pins
  card_if_pkg::mode_type     mode;                               // Personality
  card_if_pkg::access_type   access;                             // Decode
  logic [15:0]               hostDataOut, hostDataOe, coreWrData; // Data outputs
  logic                      isMaster, batt_detect_one, batt_detect_one_oe; // Status outputs
  logic                      batt_detect_two, batt_detect_two_oe, insert_detect_a_n, insert_detect_b_n;
  logic                      pass_diag_n_out, pass_diag_n_oe;    // Diagnostic pin
  logic                      drive_active_slave_present_n_out, drive_active_slave_present_n_oe; // Active pin
  int                        num_errors = 0, n_compared = 0;     // Counters
  wire logic pdLine = pass_diag_n_oe ? pass_diag_n_out : 1'b1;   // Pulled-up diagnostic line
  wire logic daLine = drive_active_slave_present_n_oe ? drive_active_slave_present_n_out : 1'b1; // Pulled-up line

  // Free-running system clock, 25 ns period
  always #12.5 clk_sys = ~clk_sys;

  card_host_signal_interface i_dut (
    .clk_sys, .srst, .powerUpOe_n, .hostAddr, .attrSelect_n, .card_enable_low_n, .card_enable_high_n,
    .cable_select_n, .dataXfer, .readCycle, .coreRdData, .hostDataIn, .ready_busy_state, .writeProtect,
    .alertEnable, .ioModeSel, .pass_diag_n_in(pdLine), .passDiagAssert, .drive_active_slave_present_n_in(daLine),
    .driveActiveAssert, .mode, .access, .hostDataOut, .hostDataOe, .coreWrData, .isMaster, .batt_detect_one,
    .batt_detect_one_oe, .batt_detect_two, .batt_detect_two_oe, .pass_diag_n_out, .pass_diag_n_oe,
    .drive_active_slave_present_n_out, .drive_active_slave_present_n_oe, .insert_detect_a_n, .insert_detect_b_n
  );
  host_bus_model i_host (
    .clk_sys, .go, .ideHost, .req, .hostAddr, .attrSelect_n, .card_enable_low_n, .card_enable_high_n
  );

  // Compare one value with its expectation
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  // Report counts and verdict, then stop
  task automatic wrap_up;
    $display("compared %0d, mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  // Reset for 20 cycles with the given strap level
  task automatic do_reset(input logic strap_n);
    @(posedge clk_sys);
    srst <= 1'b1;
    go <= 1'b0;
    powerUpOe_n <= strap_n;
    ideHost <= ~strap_n;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    go <= 1'b1;
  endtask : do_reset

  // One access held on the pins; results compared with the bench model
  task automatic xfer(input bit lo, input bit hi, input bit at, input bit rd, input bit dx, input logic [10:0] a);
    logic [15:0] rw, dw, ew;  // Core word, pin word, expected write word
    int          sp, rm, wm;  // Expected space, read lanes, write lanes
    bit          sw;          // Odd byte steered to low lane
    rw = 16'($urandom);
    dw = 16'($urandom);
    if (ideHost) begin
      a = {8'h00, a[2:0]};
      sp = lo ? card_if_pkg::SEL_TASKFILE : hi ? card_if_pkg::SEL_CTRL_BLOCK : card_if_pkg::SEL_NONE;
      rm = (lo && dx && a == 11'h000) ? 'hFFFF : (lo || hi) ? 'h00FF : 0;
      wm = rm;
      ew = dw;
      sw = 1'b0;
    end else begin
      sp = !(lo || hi) ? card_if_pkg::SEL_NONE : (at && a >= 11'h200) ? card_if_pkg::SEL_CONFIG : at ?
           card_if_pkg::SEL_CIS : ioModeSel ? card_if_pkg::SEL_IO_PORT : card_if_pkg::SEL_COMMON;
      sw = lo && !hi && a[0];
      rm = (lo && hi) ? 'hFFFF : lo ? 'h00FF : hi ? 'hFF00 : 0;
      wm = (lo && hi) ? 'hFFFF : (sw || hi) ? 'hFF00 : lo ? 'h00FF : 0;
      ew = {(lo && !hi) ? dw[7:0] : dw[15:8], dw[7:0]};
    end
    @(posedge clk_sys);
    req <= '{a, at, lo, hi};
    readCycle <= rd;
    dataXfer <= dx;
    coreRdData <= rw;
    hostDataIn <= dw;
    ready_busy_state <= 1'($urandom);
    writeProtect <= 1'($urandom);
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(16'(access.space), 16'(sp), "space");
    chk(hostDataOe, rd ? 16'(rm) : 16'h0000, "lane enables");
    chk(hostDataOut & 16'(rm), {rw[15:8], sw ? rw[15:8] : rw[7:0]} & 16'(rm), "read lanes");
    chk(coreWrData & 16'(wm), ew & 16'(wm), "write lanes");
    chk(16'(access.oddOnLow), 16'(sw), "odd steering");
  endtask : xfer

  // Every enable, space and direction combination (no double enable in ATA mode) at boundary and random addresses
  task automatic sweep;
    logic [10:0] a;  // Address of one access
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 16; k++) begin
        a = (r == 0) ? 11'h1FF : (r == 1) ? 11'h200 : 11'($urandom);
        xfer(k[0], k[1] && !(ideHost && k[0]), k[2], k[3], k[2], a);
      end
    end
  endtask : sweep

  // Main sequence: memory personality, then I/O, then ATA personality after a second reset
  initial begin
    void'($urandom(32));
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    go <= 1'b1;
    @(negedge clk_sys);
    chk(16'(mode), 16'(card_if_pkg::MODE_MEMORY), "strap high");
    chk(16'({insert_detect_a_n, insert_detect_b_n}), 16'h0000, "insert detect");
    chk(16'({batt_detect_one, batt_detect_two}), 16'h0003, "battery detect");
    chk(16'(isMaster), 16'h0000, "cable select ignored");
    sweep();
    $display("test memory lanes done");
    @(posedge clk_sys);
    ioModeSel <= 1'b1;
    sweep();
    @(posedge clk_sys);
    alertEnable <= 1'b0;
    @(posedge clk_sys);
    alertEnable <= 1'b1;
    @(negedge clk_sys);
    chk(16'({batt_detect_one, batt_detect_two}), 16'h0003, "io pins idle");
    @(posedge clk_sys);
    ready_busy_state <= ~ready_busy_state;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk(16'(batt_detect_one), 16'h0000, "status alert");
    $display("test io mode done");
    do_reset(1'b0);
    @(negedge clk_sys);
    chk(16'(mode), 16'(card_if_pkg::MODE_IDE), "strap low");
    for (int c = 0; c < 2; c++) begin
      @(posedge clk_sys);
      cable_select_n <= c[0];
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(16'(isMaster), 16'(!c[0]), "master select");
    end
    for (int h = 1; h >= 0; h--) begin
      @(posedge clk_sys);
      passDiagAssert <= h[0];
      driveActiveAssert <= h[0];
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(16'({pdLine, daLine}), h[0] ? 16'h0000 : 16'h0003, "handshake lines");
    end
    sweep();
    $display("test ata lanes done");
    wrap_up();
  end

  // Watchdog well beyond the expected run of under a thousand cycles
  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end
endmodule : testbench
